/* File: aimx_seq.sv */
// Input select register and sample/convert sequencer.
// Assumes an AXI4-Lite master on clk, and an analog mux and converter
// core that obey the select and phase outputs.
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module aimx_seq (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output var  logic             s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output var  logic             s_axi_wready,
  output var  logic [1:0]       s_axi_bresp,
  output var  logic             s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output var  logic             s_axi_arready,
  output var  logic [31:0]      s_axi_rdata,
  output var  logic [1:0]       s_axi_rresp,
  output var  logic             s_axi_rvalid,
  input  wire logic             s_axi_rready,
  output var  aimx_pkg::aimx_sel_t mux_sel,
  output var  logic             mux_set_b,
  output var  logic             sample_on,
  output var  logic             convert_on,
  output var  logic             discharge_on,
  output var  logic             conv_done
);
  import aimx_pkg::*;

  // ----------------------------------------------------------------
  // Registers and bus state
  // ----------------------------------------------------------------
  logic [15:0] sel_r;
  logic        res12_r;
  logic        alt_r;
  logic        sample_request_bit_req_r;
  logic        set_b_r;
  logic        aw_got_r;
  logic        w_got_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  aimx_state_t state_r;
  logic [4:0]  tad_cnt_r;
  logic [4:0]  acq_cnt_r;
  logic        tick;
  logic        tick_sync;
  logic        wr_go;
  logic        ctrl_wr;
  logic [4:0]  sb_wr;
  logic [4:0]  sa_wr;
  logic        sb_ok;
  logic        sa_ok;
  logic        sample_request_bit_start;
  logic        conv_end;
  logic        dis_end;

  // ----------------------------------------------------------------
  // Converter clock
  // ----------------------------------------------------------------
  // The divider restarts on the start write so that the wait before
  // sampling is counted in whole converter clock periods.
  assign tick_sync = ctrl_wr && wdata_r[CTRL_SAMPLE_REQUEST_BIT] && state_r == AIMX_IDLE;

  aimx_tick #(
    .DIV (TAD_CYC)
  ) u_tick (
    .clk   (clk),
    .rst_b (rst_b),
    .sync  (tick_sync),
    .tick  (tick)
  );

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  // A write completes once address and data are both held.
  assign wr_go   = aw_got_r && w_got_r && !s_axi_bvalid;
  assign ctrl_wr = wr_go && awaddr_r == CTRL_OFS && wstrb_r[0];
  assign sb_wr   = wdata_r[SB_LSB +: 5];
  assign sa_wr   = wdata_r[SA_LSB +: 5];

  // A positive code in the reserved range must never reach the mux.
  assign sb_ok   = !(sb_wr >= POS_RSV_LO && sb_wr <= POS_RSV_HI)
                   && sb_wr != POS_RSV_TOP;
  assign sa_ok   = !(sa_wr >= POS_RSV_LO && sa_wr <= POS_RSV_HI)
                   && sa_wr != POS_RSV_TOP;

  // Each ready pulses on alternate idle cycles and stays low from the
  // hand-over of its channel until the write response is taken.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_got_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_got_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r      <= 1'b1;
        awaddr_r      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r      <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_r == SEL_OFS || awaddr_r == CTRL_OFS
                         || awaddr_r == STAT_OFS) ? RESP_OKAY : RESP_SLV;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Select register; a byte holding a reserved positive code is ignored.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_r <= SEL_RST;
    end else if (wr_go && awaddr_r == SEL_OFS) begin
      if (wstrb_r[1] && sb_ok) begin
        sel_r[15:8] <= wdata_r[15:8];
      end
      if (wstrb_r[0] && sa_ok) begin
        sel_r[7:0] <= wdata_r[7:0];
      end
    end
  end

  // Control bits; written together with the start request.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      res12_r <= 1'b0;
      alt_r   <= 1'b0;
    end else if (ctrl_wr) begin
      res12_r <= wdata_r[CTRL_RES];
      alt_r   <= wdata_r[CTRL_ALT];
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  // Read data are taken from the address at the hand-over edge.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= RESP_OKAY;
        unique case (s_axi_araddr)
          SEL_OFS:  s_axi_rdata <= {16'h0000, sel_r};
          CTRL_OFS: s_axi_rdata <= {29'h0, alt_r, res12_r, sample_request_bit_req_r};
          STAT_OFS: s_axi_rdata <= {28'h0, set_b_r, 3'(state_r)};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLV;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Phase ends, each on the converter clock tick that closes it.
  assign sample_request_bit_start = state_r == AIMX_WAIT && tick && tad_cnt_r == 5'h01;
  assign conv_end   = state_r == AIMX_CONV && tick && tad_cnt_r == 5'h01;
  assign dis_end    = state_r == AIMX_DIS && tick && tad_cnt_r == 5'h01;

  // Request bit: set by software, cleared by hardware when sampling
  // starts; a new write wins over the clear.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sample_request_bit_req_r <= 1'b0;
    end else if (ctrl_wr && wdata_r[CTRL_SAMPLE_REQUEST_BIT]) begin
      sample_request_bit_req_r <= 1'b1;
    end else if (sample_request_bit_start) begin
      sample_request_bit_req_r <= 1'b0;
    end
  end

  // Acquisition counter runs through sample and the switch-back cycle.
  // It saturates at the acquisition count so it cannot wrap.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acq_cnt_r <= 5'h00;
    end else if (state_r == AIMX_SAMPLE_REQUEST_BIT || state_r == AIMX_SWB) begin
      if (acq_cnt_r != 5'(TACQ_CYC)) begin
        acq_cnt_r <= acq_cnt_r + 5'h01;
      end
    end else begin
      acq_cnt_r <= 5'h00;
    end
  end

  // End-of-conversion pulse, one cycle wide.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_done <= 1'b0;
    end else begin
      conv_done <= conv_end;
    end
  end

  // ----------------------------------------------------------------
  // Setting select
  // ----------------------------------------------------------------
  // The setting flips as discharge ends, so that the mux already
  // routes the new setting when sample_on rises in the switch-back
  // cycle.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      set_b_r <= 1'b0;
    end else if (dis_end && alt_r) begin
      set_b_r <= !set_b_r;
    end
  end

  // A start request while running only sets the request bit.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r   <= AIMX_IDLE;
      tad_cnt_r <= 5'h00;
    end else begin
      unique case (state_r)
        AIMX_IDLE: begin
          if (tick_sync) begin
            state_r   <= AIMX_WAIT;
            tad_cnt_r <= 5'(START_TAD);
          end
        end
        AIMX_WAIT: begin
          if (tick) begin
            if (tad_cnt_r == 5'h01) begin
              state_r   <= AIMX_SAMPLE_REQUEST_BIT;
              tad_cnt_r <= 5'(SAMPLE_REQUEST_BIT_TAD);
            end else begin
              tad_cnt_r <= tad_cnt_r - 5'h01;
            end
          end
        end
        AIMX_SAMPLE_REQUEST_BIT: begin
          if (tick) begin
            if (tad_cnt_r > 5'h01) begin
              tad_cnt_r <= tad_cnt_r - 5'h01;
            end else if (acq_cnt_r == 5'(TACQ_CYC)) begin
              state_r   <= AIMX_CONV;
              tad_cnt_r <= res12_r ? 5'(CONV12_TAD) : 5'(CONV10_TAD);
            end
          end
        end
        AIMX_CONV: begin
          if (tick) begin
            if (tad_cnt_r == 5'h01) begin
              state_r   <= AIMX_DIS;
              tad_cnt_r <= 5'(DIS_TAD);
            end else begin
              tad_cnt_r <= tad_cnt_r - 5'h01;
            end
          end
        end
        AIMX_DIS: begin
          if (tick) begin
            if (tad_cnt_r == 5'h01) begin
              state_r <= AIMX_SWB;
            end else begin
              tad_cnt_r <= tad_cnt_r - 5'h01;
            end
          end
        end
        // Switch-back: one sampling cycle on the device clock.
        AIMX_SWB: begin
          state_r   <= AIMX_SAMPLE_REQUEST_BIT;
          tad_cnt_r <= 5'(SAMPLE_REQUEST_BIT_TAD);
        end
        default: state_r <= AIMX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs to the analog side
  // ----------------------------------------------------------------
  // Outputs copy the sequencer one cycle late, so all phases and the
  // routing change together on the same edge.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mux_sel      <= '0;
      mux_set_b    <= 1'b0;
      sample_on    <= 1'b0;
      convert_on   <= 1'b0;
      discharge_on <= 1'b0;
    end else begin
      mux_set_b    <= set_b_r;
      mux_sel.neg  <= set_b_r ? sel_r[NB_LSB +: 3] : sel_r[NA_LSB +: 3];
      mux_sel.pos  <= set_b_r ? sel_r[SB_LSB +: 5] : sel_r[SA_LSB +: 5];
      sample_on    <= state_r == AIMX_SAMPLE_REQUEST_BIT || state_r == AIMX_SWB;
      convert_on   <= state_r == AIMX_CONV;
      discharge_on <= state_r == AIMX_DIS;
    end
  end

endmodule : aimx_seq
`default_nettype wire

/* File: aimx_pkg.sv */
// Package for the converter input select and sequencer block.
// Assumes a 25 MHz device clock and an AXI4-Lite register bus.
package aimx_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  SEL_OFS   = 8'h00;
  localparam logic [7:0]  CTRL_OFS  = 8'h04;
  localparam logic [7:0]  STAT_OFS  = 8'h08;
  localparam logic [15:0] SEL_RST   = 16'h0000;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLV  = 2'h2;

  // Control bits.
  localparam int CTRL_SAMPLE_REQUEST_BIT = 0;
  localparam int CTRL_RES  = 1;
  localparam int CTRL_ALT  = 2;

  // Select field positions.
  localparam int NB_LSB = 13;
  localparam int SB_LSB = 8;
  localparam int NA_LSB = 5;
  localparam int SA_LSB = 0;

  // Positive codes reserved; must not be used.
  localparam logic [4:0] POS_RSV_LO = 5'h12;
  localparam logic [4:0] POS_RSV_HI = 5'h19;
  localparam logic [4:0] POS_RSV_TOP = 5'h1F;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS     = 40;
  localparam int TAD_MIN_NS = 600;
  localparam int TACQ_NS    = 750;
  localparam int TAD_CYC    = (TAD_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int TACQ_CYC   = (TACQ_NS + CLK_NS - 1) / CLK_NS;
  localparam int START_TAD  = 2;
  localparam int SAMPLE_REQUEST_BIT_TAD   = 1;
  localparam int CONV10_TAD = 12;
  localparam int CONV12_TAD = 14;
  localparam int DIS_TAD    = 12;

  typedef enum logic [2:0] {
    AIMX_IDLE, AIMX_WAIT, AIMX_SAMPLE_REQUEST_BIT, AIMX_CONV, AIMX_DIS, AIMX_SWB
  } aimx_state_t;

  typedef struct packed {
    logic [2:0] neg;
    logic [4:0] pos;
  } aimx_sel_t;

endpackage : aimx_pkg

/* File: aimx_tick.sv */
// Converter clock tick generator.
// Assumes the device clock; emits a one-cycle tick every TAD period.
`timescale 1ns/1ps
`default_nettype none
module aimx_tick #(
  parameter int DIV = 15
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic sync,
  output var  logic tick
);
  logic [7:0] cnt_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 8'h00;
      tick  <= 1'b0;
    end else if (sync || cnt_r == 8'(DIV - 1)) begin
      cnt_r <= 8'h00;
      tick  <= !sync;
    end else begin
      cnt_r <= cnt_r + 8'h01;
      tick  <= 1'b0;
    end
  end
endmodule : aimx_tick
`default_nettype wire

/* File: aimx_amux_model.sv */
// Model of the analog mux and converter core.
// Assumes it only watches sample_on and the select outputs.
`timescale 1ns/1ps
`default_nettype none
module aimx_amux_model (
  input  wire logic                clk,
  input  wire logic                sample_on,
  input  wire aimx_pkg::aimx_sel_t mux_sel,
  input  wire logic                mux_set_b,
  output var  aimx_pkg::aimx_sel_t held_sel,
  output var  logic                held_b,
  output var  int                  starts
);
  import aimx_pkg::*;
  logic sample_request_bit_q;
  initial starts = 0;
  // The routing is latched as each sample starts.
  always @(posedge clk) begin
    sample_request_bit_q <= sample_on;
    if (sample_on && !sample_request_bit_q) begin
      held_sel <= mux_sel;
      held_b   <= mux_set_b;
      starts   <= starts + 1;
    end
  end
endmodule : aimx_amux_model
`default_nettype wire

/* File: aimx_seq_chk.sv */
// Checker of the sequencer phase outputs.
// Assumes a bind to aimx_seq; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module aimx_seq_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sample_on,
  input wire logic convert_on,
  input wire logic discharge_on,
  input wire logic conv_done
);
  import aimx_pkg::*;
  logic [2:0] ph_r;
  logic [8:0] run_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Length in cycles of the phase in force up to the last edge.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ph_r  <= 3'h0;
      run_r <= 9'h000;
    end else begin
      ph_r  <= {sample_on, convert_on, discharge_on};
      if ({sample_on, convert_on, discharge_on} != ph_r)
        run_r <= 9'h001;
      else
        run_r <= run_r + 9'h001;
    end
  end
  sequence conv_end_s;
    $fell(convert_on);
  endsequence
  sequence dis_end_s;
    $fell(discharge_on);
  endsequence
  phase_excl_a:
    assert property ($onehot0({sample_on, convert_on, discharge_on}))
      else $error("phases overlap");
  conv_len_a:
    assert property (conv_end_s |-> run_r == CONV10_TAD * TAD_CYC ||
                     run_r == CONV12_TAD * TAD_CYC)
      else $error("convert length wrong");
  sample_request_bit_len_a:
    assert property ($rose(convert_on) |-> $past(sample_on) &&
                     run_r >= TACQ_CYC)
      else $error("sample too short");
  dis_len_a:
    assert property (dis_end_s |-> run_r >= DIS_TAD * TAD_CYC)
      else $error("discharge too short");
  conv_dis_a:
    assert property (conv_end_s |-> discharge_on)
      else $error("no discharge after convert");
  back_sample_request_bit_a:
    assert property (dis_end_s |-> sample_on)
      else $error("no switch-back");
  done_pos_a:
    assert property (conv_done |-> convert_on || $past(convert_on))
      else $error("done outside convert end");
  done_once_a:
    assert property (conv_done |=> !conv_done)
      else $error("done longer than a cycle");
  done_end_a:
    assert property (conv_end_s |-> $past(conv_done))
      else $error("no done pulse at convert end");
endmodule : aimx_seq_chk
bind aimx_seq aimx_seq_chk u_chk (
  .clk(clk), .rst_b(rst_b), .sample_on(sample_on),
  .convert_on(convert_on), .discharge_on(discharge_on),
  .conv_done(conv_done));
`default_nettype wire

/* File: test_adc_input_mux_and_sequencer.sv */
// Testbench of the select register and sequencer.
// Assumes the design, checker and mux model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_adc_input_mux_and_sequencer;
  import aimx_pkg::*;
  logic        clk, rst_b, awv, awr, wv, wrd, bv, bry, arv, arr, rv, rry;
  logic [7:0]  aw, ar;
  logic [31:0] wd, rdt;
  logic [1:0]  brs, rrs;
  logic [3:0]  ws;
  aimx_sel_t   msel, hsel;
  logic        setb, hb, smp, cnv, dis, done;
  int          bad_count, total_checks, cyc, starts;
  aimx_seq u_dut (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(aw),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(brs), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdt), .s_axi_rresp(rrs), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .mux_sel(msel), .mux_set_b(setb),
    .sample_on(smp), .convert_on(cnv), .discharge_on(dis),
    .conv_done(done));
  aimx_amux_model u_mux (.clk(clk), .sample_on(smp), .mux_sel(msel),
    .mux_set_b(setb), .held_sel(hsel), .held_b(hb), .starts(starts));
  task automatic chk(input string nm, input logic [31:0] e, s);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
    @(posedge clk);
    aw  <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv);
    chk("bresp", {30'h0, er}, {30'h0, brs});
    bry <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
    @(posedge clk);
    ar  <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    chk("rdata", e, rdt);
    chk("rresp", {30'h0, er}, {30'h0, rrs});
    rry <= 1'b0;
  endtask : rchk
  // Starts the sequence, then times the start delay and the convert.
  task automatic go(input logic [31:0] c, input int cv);
    int n;
    wr(CTRL_OFS, c);
    n = 0;
    while (!smp) begin
      @(posedge clk);
      n++;
    end
    chk("start", 32'h1, {31'h0, n >= 2 * TAD_CYC && n <= 3 * TAD_CYC + 2});
    while (!cnv) @(posedge clk);
    n = 0;
    while (cnv) begin
      @(posedge clk);
      n++;
    end
    chk("conv", cv, n);
  endtask : go
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    int   k;
    logic p;
    rst_b = 1'b0;
    {awv, wv, bry, arv, rry} = 5'h00;
    aw = 8'h00;
    ar = 8'h00;
    wd = 32'h0;
    ws = 4'hF;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rchk(SEL_OFS, 32'h0, RESP_OKAY);
    rchk(8'h0C, 32'h0, RESP_SLV);
    wr(8'h0C, 32'h1, RESP_SLV);
    wr(SEL_OFS, 32'hF1F1);
    rchk(SEL_OFS, 32'hF1F1, RESP_OKAY);
    wr(SEL_OFS, 32'hE012);
    rchk(SEL_OFS, 32'hE0F1, RESP_OKAY);
    wr(SEL_OFS, 32'h1F6B);
    rchk(SEL_OFS, 32'hE06B, RESP_OKAY);
    wr(SEL_OFS, 32'h3A2E);
    go(32'h1, CONV10_TAD * TAD_CYC);
    chk("sel", 32'h2E, {24'h0, hsel});
    chk("setb", 32'h0, {31'h0, hb});
    rchk(CTRL_OFS, 32'h0, RESP_OKAY);
    rst_b <= 1'b0;
    @(posedge clk);
    chk("mux", 32'h0, {24'h0, msel});
    rst_b <= 1'b1;
    rchk(SEL_OFS, 32'h0, RESP_OKAY);
    ws <= 4'h2;
    wr(SEL_OFS, 32'h3A2E);
    rchk(SEL_OFS, 32'h3A00, RESP_OKAY);
    ws <= 4'hF;
    wr(SEL_OFS, 32'h3A2E);
    go(32'h7, CONV12_TAD * TAD_CYC);
    rchk(CTRL_OFS, 32'h6, RESP_OKAY);
    for (int i = 0; i < 2; i++) begin
      k = starts;
      p = hb;
      while (starts == k) @(posedge clk);
      chk("alt", {31'h0, ~p}, {31'h0, hb});
      chk("sel", hb ? 32'h3A : 32'h2E, {24'h0, hsel});
    end
    close_out();
  end
endmodule : test_adc_input_mux_and_sequencer
`default_nettype wire
